// file: hdl/mii_mac_pins.sv
// mac side of the nibble/serial pin interface with management clock
//
// Notes on behaviour
// - transmit enable follows transmit clock, high from first nibble through last.
// - transmit enable drops just after the transmit clock rise that follows the last nibble.
// - one nibble per transmit clock while enabled; data quiet otherwise.
// - serial mode sends frame bits on data bit 0 only.
// - capture one nibble per receive clock while valid; ignore data otherwise.
// - receive error during a frame marks that frame as bad.
// - receive error is ignored while receive valid is low.
// - serial mode receives frame bits from data bit 0, qualified by valid.
// - carrier sense is asynchronous and is synchronised before use.
// - collision is ignored in full-duplex mode.
// - collision is asynchronous and is resynchronised internally.
// - the mac generates the management clock itself.
// - management clock phases at least 160 ns, period at least 400 ns.
// - mac drives management data at the clock's fall; reads at its rise.
`timescale 1ns/1ps
`default_nettype none
module mii_mac_pins
	import mii_pkg::*;
#(
	parameter int MDC_HALF = mii_pkg::MDC_HALF_CYC
) (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic                     serial_mode,
	input  wire logic                     full_duplex,
	input  wire logic                     tx_clk,
	output logic                          tx_en,
	output logic [mii_pkg::NIB_W-1:0]     txd,
	input  wire logic                     rx_clk,
	input  wire logic                     rx_dv,
	input  wire logic                     rx_er,
	input  wire logic [mii_pkg::NIB_W-1:0] rxd,
	input  wire logic                     crs,
	input  wire logic                     col,
	output logic                          mdc,
	input  wire logic                     mdio_in,
	output logic                          mdio_out,
	output logic                          mdio_oe_n,
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [mii_pkg::NIB_W-1:0] in_data,
	output logic                          out_valid,
	output logic [mii_pkg::NIB_W-1:0]     out_data,
	output logic                          out_end,
	output logic                          out_bad,
	output logic                          carrier,
	output logic                          collision,
	input  wire logic                     mgmt_run,
	input  wire logic                     mgmt_drive,
	input  wire logic                     mgmt_tx_bit,
	output logic                          mgmt_rx_bit,
	output logic                          mgmt_rx_stb
);
	import mii_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// synchronisers: first stage feeds only the second
	logic [SYNC_W-1:0] meta;
	logic [SYNC_W-1:0] sync;
	logic              tx_clk_d;
	logic              rx_clk_d;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta     <= SYNC_RST;
			sync     <= SYNC_RST;
			tx_clk_d <= 1'b1;
			rx_clk_d <= 1'b1;
		end else begin
			meta     <= {tx_clk, rx_clk, rx_dv, rx_er, rxd, crs, col, mdio_in};
			sync     <= meta;
			tx_clk_d <= sync[10];
			rx_clk_d <= sync[9];
		end
	end
	logic                  tx_rise;
	logic                  rx_rise;
	logic                  dv_s;
	logic                  er_s;
	logic [NIB_W-1:0]      rxd_s;
	logic                  mdio_s;
	assign tx_rise = sync[10] & ~tx_clk_d;
	assign rx_rise = sync[9] & ~rx_clk_d;
	assign dv_s    = sync[8];
	assign er_s    = sync[7];
	assign rxd_s   = sync[6:3];
	assign mdio_s  = sync[0];
	assign carrier = sync[2];
	a_crs_sync: assert property (@(posedge clk) disable iff (!nrst)
		$rose(carrier) |-> $past(crs, 2)) else $error("carrier skipped synchroniser");

	////////////////////////////////////////////////////////////////////////////////
	// two-entry transmit buffer; in_ready stalls the source when full
	logic [NIB_W-1:0] buf_mem [2];
	logic             wr_ptr;
	logic             rd_ptr;
	logic [1:0]       buf_cnt;
	logic             pop;
	logic             push;
	logic             buf_valid;
	assign buf_valid = (buf_cnt != 2'h0);
	assign in_ready  = (buf_cnt != 2'h2);
	assign push      = in_valid & in_ready;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr  <= 1'b0;
			rd_ptr  <= 1'b0;
			buf_cnt <= 2'h0;
		end else begin
			wr_ptr  <= wr_ptr ^ push;
			rd_ptr  <= rd_ptr ^ pop;
			buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
		end
	end
	always_ff @(posedge clk) begin
		if (push) begin
			buf_mem[wr_ptr] <= in_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode latch and collision gate
	logic ser;
	logic next_ser;
	logic next_collision;
	logic rx_act;
	always_comb begin
		// mode taken only while both paths idle and no frame can start
		next_ser = (!tx_en && !rx_act && !tx_rise && !rx_rise) ? serial_mode : ser;
		// synchronised collision, masked in full duplex
		next_collision = sync[1] & ~full_duplex;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ser       <= 1'b0;
			collision <= 1'b0;
		end else begin
			ser       <= next_ser;
			collision <= next_collision;
		end
	end
	a_col_fdx: assert property (@(posedge clk) disable iff (!nrst)
		full_duplex |=> !collision) else $error("collision seen in full duplex");

	////////////////////////////////////////////////////////////////////////////////
	// transmit: outputs change just after the detected rise of the link clock
	mii_tx_st_t       tx_st;
	mii_tx_st_t       next_tx_st;
	logic             next_tx_en;
	logic [NIB_W-1:0] next_txd;
	logic [NIB_W-1:0] tx_sh;
	logic [NIB_W-1:0] next_tx_sh;
	logic [1:0]       tx_bits;
	logic [1:0]       next_tx_bits;
	always_comb begin
		next_tx_st   = tx_st;
		next_tx_en   = tx_en;
		next_txd     = txd;
		next_tx_sh   = tx_sh;
		next_tx_bits = tx_bits;
		pop          = 1'b0;
		if (tx_rise) begin
			if (tx_st == MII_TX_SEND && ser && tx_bits != 2'h0) begin
				// remaining bits of the nibble on bit 0
				next_txd     = {3'h0, tx_sh[0]};
				next_tx_sh   = tx_sh >> 1;
				next_tx_bits = tx_bits - 2'h1;
			end else if (buf_valid) begin
				// enable rises with the first nibble
				pop          = 1'b1;
				next_tx_st   = MII_TX_SEND;
				next_tx_en   = 1'b1;
				next_txd     = ser ? {3'h0, buf_mem[rd_ptr][0]} : buf_mem[rd_ptr];
				next_tx_sh   = buf_mem[rd_ptr] >> 1;
				next_tx_bits = ser ? SER_LAST_BIT : 2'h0;
			end else begin
				// no data left: frame ends at this edge
				next_tx_st = MII_TX_IDLE;
				next_tx_en = 1'b0;
				next_txd   = TXD_RST;
			end
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_st   <= MII_TX_IDLE;
			tx_en   <= 1'b0;
			txd     <= TXD_RST;
			tx_sh   <= '0;
			tx_bits <= 2'h0;
		end else begin
			tx_st   <= next_tx_st;
			tx_en   <= next_tx_en;
			txd     <= next_txd;
			tx_sh   <= next_tx_sh;
			tx_bits <= next_tx_bits;
		end
	end
	a_tx_en_edge: assert property (@(posedge clk) disable iff (!nrst)
		$changed(tx_en) |-> $past(tx_rise)) else $error("tx_en moved off a tx clock edge");
	a_tx_end_drop: assert property (@(posedge clk) disable iff (!nrst)
		tx_rise && !buf_valid && !(tx_st == MII_TX_SEND && ser && tx_bits != 2'h0) |=> !tx_en)
		else $error("tx_en held after last nibble");
	a_txd_quiet: assert property (@(posedge clk) disable iff (!nrst)
		!tx_en |-> txd == TXD_RST) else $error("txd active without tx_en");
	a_serial_bit0: assert property (@(posedge clk) disable iff (!nrst)
		ser && tx_en |-> txd[3:1] == 3'h0) else $error("serial mode used upper txd bits");

	////////////////////////////////////////////////////////////////////////////////
	// receive: the phy cannot be stalled, so nibbles leave as one-cycle pulses
	logic             rx_err;
	logic             next_rx_err;
	logic             next_rx_act;
	logic [NIB_W-1:0] rx_sh;
	logic [NIB_W-1:0] next_rx_sh;
	logic [1:0]       rx_bits;
	logic [1:0]       next_rx_bits;
	logic             next_out_valid;
	logic [NIB_W-1:0] next_out_data;
	logic             next_out_end;
	logic             next_out_bad;
	always_comb begin
		next_rx_err    = rx_err;
		next_rx_act    = rx_act;
		next_rx_sh     = rx_sh;
		next_rx_bits   = rx_bits;
		next_out_valid = 1'b0;
		next_out_data  = out_data;
		next_out_end   = 1'b0;
		next_out_bad   = out_bad;
		if (rx_rise) begin
			if (dv_s) begin
				next_rx_act = 1'b1;
				if (er_s) begin
					next_rx_err = 1'b1;
				end
				if (ser) begin
					next_rx_sh   = {rxd_s[0], rx_sh[3:1]};
					next_rx_bits = rx_bits + 2'h1;
					if (rx_bits == SER_LAST_BIT) begin
						next_out_valid = 1'b1;
						next_out_data  = {rxd_s[0], rx_sh[3:1]};
					end
				end else begin
					next_out_valid = 1'b1;
					next_out_data  = rxd_s;
				end
			end else if (rx_act) begin
				// error not sampled outside the frame
				next_out_end = 1'b1;
				next_out_bad = rx_err;
				next_rx_err  = 1'b0;
				next_rx_act  = 1'b0;
				next_rx_bits = 2'h0;
			end
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_err    <= 1'b0;
			rx_act    <= 1'b0;
			rx_sh     <= '0;
			rx_bits   <= 2'h0;
			out_valid <= 1'b0;
			out_data  <= '0;
			out_end   <= 1'b0;
			out_bad   <= 1'b0;
		end else begin
			rx_err    <= next_rx_err;
			rx_act    <= next_rx_act;
			rx_sh     <= next_rx_sh;
			rx_bits   <= next_rx_bits;
			out_valid <= next_out_valid;
			out_data  <= next_out_data;
			out_end   <= next_out_end;
			out_bad   <= next_out_bad;
		end
	end
	a_rx_capture: assert property (@(posedge clk) disable iff (!nrst)
		!ser && rx_rise && dv_s |=> out_valid && out_data == $past(rxd_s))
		else $error("nibble not captured");
	a_rx_err_mark: assert property (@(posedge clk) disable iff (!nrst)
		rx_rise && dv_s && er_s |=> rx_err) else $error("receive error not latched");
	a_rx_err_idle: assert property (@(posedge clk) disable iff (!nrst)
		rx_rise && !dv_s |=> !rx_err) else $error("receive error kept outside frame");

	////////////////////////////////////////////////////////////////////////////////
	// management clock; a stop waits for the low phase so no short pulse escapes
	logic [15:0] mdc_cnt;
	logic [15:0] next_mdc_cnt;
	logic        next_mdc;
	logic        next_mdio_out;
	logic        next_mdio_oe_n;
	logic        next_mgmt_rx_bit;
	logic        next_mgmt_rx_stb;
	logic        mdc_flip;
	always_comb begin
		// each phase lasts MDC_HALF cycles at least
		mdc_flip         = (mdc_cnt >= 16'(MDC_HALF - 1)) && (mgmt_run || mdc);
		next_mdc_cnt     = mdc_flip ? 16'h0000 :
		                   ((mdc_cnt >= 16'(MDC_HALF - 1)) ? mdc_cnt : mdc_cnt + 16'h0001);
		next_mdc         = mdc ^ mdc_flip;
		next_mdio_out    = mdio_out;
		next_mdio_oe_n   = mdio_oe_n;
		next_mgmt_rx_bit = mgmt_rx_bit;
		next_mgmt_rx_stb = 1'b0;
		// drive at fall, sample at rise
		if (mdc_flip && mdc) begin
			next_mdio_out  = mgmt_tx_bit;
			next_mdio_oe_n = ~mgmt_drive;
		end else if (mdc_flip) begin
			next_mgmt_rx_bit = mdio_s;
			next_mgmt_rx_stb = 1'b1;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mdc_cnt     <= 16'h0000;
			mdc         <= 1'b0;
			mdio_out    <= 1'b0;
			mdio_oe_n   <= 1'b1;
			mgmt_rx_bit <= 1'b0;
			mgmt_rx_stb <= 1'b0;
		end else begin
			mdc_cnt     <= next_mdc_cnt;
			mdc         <= next_mdc;
			mdio_out    <= next_mdio_out;
			mdio_oe_n   <= next_mdio_oe_n;
			mgmt_rx_bit <= next_mgmt_rx_bit;
			mgmt_rx_stb <= next_mgmt_rx_stb;
		end
	end
	a_mdc_phase: assert property (@(posedge clk) disable iff (!nrst)
		$changed(mdc) |-> $past(mdc_cnt) >= 16'(MDC_HALF - 1)) else $error("mdc phase too short");
	a_mdio_fall: assert property (@(posedge clk) disable iff (!nrst)
		$changed(mdio_out) |-> $past(mdc) && !mdc) else $error("mdio changed off mdc fall");
endmodule : mii_mac_pins
`default_nettype wire

// file: hdl/mii_pkg.sv
// constants for the media-independent pin interface block
package mii_pkg;
	localparam int          NIB_W             = 4;
	localparam int          CLK_PERIOD_NS     = 10;
	localparam int          MDC_MIN_PHASE_NS  = 160;
	localparam int          MDC_MIN_PERIOD_NS = 400;
	localparam int          MDC_PHASE_CYC     = (MDC_MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          MDC_PERHALF_CYC   = (MDC_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
	                                            / (2 * CLK_PERIOD_NS);
	localparam int          MDC_HALF_CYC      = (MDC_PHASE_CYC > MDC_PERHALF_CYC) ?
	                                            MDC_PHASE_CYC : MDC_PERHALF_CYC;
	localparam logic [3:0]  TXD_RST           = 4'h0;
	localparam logic [1:0]  SER_LAST_BIT      = 2'h3;
	localparam int          SYNC_W            = 11;
	// link clock bits reset high so a pin already high after reset gives no false rise
	localparam logic [10:0] SYNC_RST          = 11'h600;
	typedef enum logic { MII_TX_IDLE, MII_TX_SEND } mii_tx_st_t;
endpackage : mii_pkg

// file: test/mii_phy_model.sv
// behavioural phy: free link clocks, frame sender, transmit capture
`timescale 1ns/1ps
`default_nettype none
module mii_phy_model (
	output logic       tx_clk,
	output logic       rx_clk,
	input  wire logic  tx_en,
	input  wire logic [3:0] txd,
	output logic       rx_dv,
	output logic       rx_er,
	output logic [3:0] rxd
);
	logic [3:0] tx_q[$];
	int         tx_frames = 0;
	logic       en_d = 1'b0;
	// continuous link clocks of unrelated phase
	initial begin
		tx_clk = 1'b0;
		forever #40 tx_clk = ~tx_clk;
	end
	initial begin
		rx_clk = 1'b0;
		rx_dv = 1'b0;
		rx_er = 1'b0;
		rxd = 4'h0;
		#17;
		forever #40 rx_clk = ~rx_clk;
	end
	////////////////////////////////////////////////////////////////
	// one nibble per enabled period, frames counted at enable fall
	always @(posedge tx_clk) begin
		if (tx_en === 1'b1)
			tx_q.push_back(txd);
		if (en_d === 1'b1 && tx_en !== 1'b1)
			tx_frames++;
		en_d <= tx_en;
	end
	// valid held over the frame, dropped after the last nibble
	task automatic send(input logic [3:0] d[$], input int err);
		foreach (d[i]) begin
			@(negedge rx_clk);
			rx_dv = 1'b1;
			rxd = d[i];
			rx_er = (i == err);
		end
		@(negedge rx_clk);
		rx_dv = 1'b0;
		rx_er = (err == -2);
		// released data flips so a stale nibble cannot pass for a new one
		rxd = ~rxd;
	endtask : send
endmodule : mii_phy_model
`default_nettype wire

// file: test/tb_mii_mac_pins.sv
// self-checking bench for the mac pin interface
`timescale 1ns/1ps
`default_nettype none
module tb_mii_mac_pins;
	import mii_pkg::*;
	logic       clk = 1'b0, nrst = 1'b0, serial_mode = 1'b0, full_duplex = 1'b0;
	logic       crs = 1'b0, col = 1'b0, in_valid = 1'b0, phy_mdio = 1'b1;
	logic       mgmt_run = 1'b0, mgmt_drive = 1'b0, mgmt_tx_bit = 1'b0;
	logic [3:0] in_data = 4'h0;
	logic       tx_clk, rx_clk, tx_en, rx_dv, rx_er, mdc, mdio_in, mdio_out, mdio_oe_n;
	logic       in_ready, out_valid, out_end, out_bad, carrier, collision;
	logic       mgmt_rx_bit, mgmt_rx_stb, last_bad;
	logic [3:0] txd, rxd, out_data;
	logic [3:0] rx_q[$], q[$], e[$];
	int         miscompares = 0, n_checks = 0, n_ends = 0, n_stb = 0;
	assign mdio_in = mdio_oe_n ? phy_mdio : mdio_out;
	mii_mac_pins DUT (.clk, .nrst, .serial_mode, .full_duplex, .tx_clk, .tx_en, .txd,
		.rx_clk, .rx_dv, .rx_er, .rxd, .crs, .col, .mdc, .mdio_in, .mdio_out, .mdio_oe_n,
		.in_valid, .in_ready, .in_data, .out_valid, .out_data, .out_end, .out_bad,
		.carrier, .collision, .mgmt_run, .mgmt_drive, .mgmt_tx_bit, .mgmt_rx_bit,
		.mgmt_rx_stb);
	mii_phy_model phy (.tx_clk, .rx_clk, .tx_en, .txd, .rx_dv, .rx_er, .rxd);
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (out_valid === 1'b1)
			rx_q.push_back(out_data);
		if (mgmt_rx_stb === 1'b1)
			n_stb++;
		if (out_end === 1'b1) begin
			last_bad = out_bad;
			n_ends++;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic tx_frame(input logic mode, input logic [3:0] d[$]);
		logic [3:0] x[$];
		int         f0;
		int         w;
		logic       full;
		serial_mode <= mode;
		@(posedge clk);
		phy.tx_q.delete();
		f0 = phy.tx_frames;
		full = 1'b0;
		w = 0;
		foreach (d[i]) begin
			if (mode)
				for (int b = 0; b < 4; b++) x.push_back({3'h0, d[i][b]});
			else
				x.push_back(d[i]);
		end
		// in nibble mode the buffer fills faster than the link drains it, so a refusal must show
		foreach (d[i]) begin
			in_valid <= 1'b1;
			in_data <= d[i];
			do begin
				@(posedge clk);
				if (in_ready === 1'b0) full = 1'b1;
			end while (in_ready !== 1'b1);
		end
		in_valid <= 1'b0;
		while (phy.tx_frames == f0 && w < 3000) begin
			@(posedge clk);
			w++;
		end
		check(4'(phy.tx_q.size()), 4'(x.size()));
		foreach (x[i]) check(phy.tx_q[i], x[i]);
		check({3'h0, tx_en}, 4'h0);
		check(txd, 4'h0);
		check(4'(phy.tx_frames - f0), 4'h1);
		if (!mode) check({3'h0, full}, 4'h1);
	endtask : tx_frame
	task automatic rx_frame(input logic mode, input logic [3:0] d[$], input int err,
		input logic [3:0] x[$], input logic bad);
		int n0;
		int w;
		serial_mode <= mode;
		@(posedge clk);
		rx_q.delete();
		n0 = n_ends;
		w = 0;
		phy.send(d, err);
		while (n_ends == n0 && w < 100) begin
			@(posedge clk);
			w++;
		end
		check(4'(rx_q.size()), 4'(x.size()));
		foreach (x[i]) check(rx_q[i], x[i]);
		check({3'h0, last_bad}, {3'h0, bad});
	endtask : rx_frame
	task automatic phase(output int n);
		logic v;
		v = mdc;
		n = 0;
		while (mdc === v && n < 200) begin
			@(posedge clk);
			n++;
		end
	endtask : phase
	task automatic mdc_test();
		int hi;
		int lo;
		int s0;
		s0 = n_stb;
		mgmt_run <= 1'b1;
		phase(hi);
		phase(hi);
		phase(lo);
		check({3'h0, hi == MDC_HALF_CYC && hi * 10 >= 160}, 4'h1);
		check({3'h0, lo * 10 >= 160 && (hi + lo) * 10 >= 400}, 4'h1);
		check({3'h0, mgmt_rx_bit}, 4'h1);
		mgmt_drive <= 1'b1;
		phase(hi);
		phase(lo);
		check({2'h0, mdio_oe_n, mdio_out}, 4'h0);
		check({3'h0, mgmt_rx_bit}, 4'h0);
		// the fall that ends the last high phase must still drive the new bit
		mgmt_tx_bit <= 1'b1;
		mgmt_run <= 1'b0;
		repeat (100) @(posedge clk);
		check({3'h0, mdc}, 4'h0);
		check({2'h0, mdio_oe_n, mdio_out}, 4'h1);
		check(4'(n_stb - s0), 4'h3);
	endtask : mdc_test
	task automatic carrier_test();
		// phy keeps carrier up for the whole collision
		crs <= 1'b1;
		col <= 1'b1;
		repeat (6) @(posedge clk);
		check({2'h0, carrier, collision}, 4'h3);
		full_duplex <= 1'b1;
		repeat (6) @(posedge clk);
		check({2'h0, carrier, collision}, 4'h2);
		full_duplex <= 1'b0;
		repeat (6) @(posedge clk);
		check({2'h0, carrier, collision}, 4'h3);
		crs <= 1'b0;
		col <= 1'b0;
		repeat (6) @(posedge clk);
		check({2'h0, carrier, collision}, 4'h0);
	endtask : carrier_test
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		check({tx_en, mdc, mdio_oe_n, in_ready}, 4'h3);
		q = '{4'h1, 4'h2, 4'hA, 4'hF, 4'h5, 4'h0};
		tx_frame(1'b0, q);
		q = '{4'h6, 4'h9};
		tx_frame(1'b1, q);
		q = '{4'h1, 4'h2, 4'hA, 4'hF};
		rx_frame(1'b0, q, -1, q, 1'b0);
		rx_frame(1'b0, q, 2, q, 1'b1);
		rx_frame(1'b0, q, -2, q, 1'b0);
		rx_frame(1'b0, q, -1, q, 1'b0);
		q = '{4'h3, 4'hC, 4'hD, 4'h2, 4'hC, 4'h2, 4'h3, 4'hD, 4'h3};
		e = '{4'h5, 4'hC};
		rx_frame(1'b1, q, -1, e, 1'b0);
		carrier_test();
		mdc_test();
		print_verdict();
	end
	initial begin
		#400000;
		miscompares++;
		print_verdict();
	end
endmodule : tb_mii_mac_pins
`default_nettype wire
